/* File: rtl/ufl_params.svh */
// Register offsets, field positions and reset values
// ============================================================
`ifndef UFL_PARAMS_SVH
`define UFL_PARAMS_SVH

// ============================================================
// Register byte addresses
`define UFL_OFS_DATA 6'h00
`define UFL_OFS_DIV_LOW 6'h00
`define UFL_OFS_DIV_HIGH 6'h04
`define UFL_OFS_FIFO_CTRL 6'h08
`define UFL_OFS_LINE_CTRL 6'h0C
`define UFL_OFS_DIV_FRAC 6'h10
`define UFL_OFS_FEATURE 6'h14
`define UFL_OFS_ENH_FEAT 6'h18
`define UFL_OFS_RX_THR 6'h1C
`define UFL_OFS_TX_THR 6'h20
`define UFL_OFS_STATUS 6'h24

// ============================================================
// FIFO control fields
`define UFL_FC_ENABLE 0
`define UFL_FC_RX_RST 1
`define UFL_FC_TX_RST 2
`define UFL_FC_DMA 3
`define UFL_FC_TXSEL_LO 4
`define UFL_FC_RXSEL_LO 6

// ============================================================
// Line control, feature and enhanced feature fields
`define UFL_LC_PAR_EN 3
`define UFL_LC_EVEN 4
`define UFL_LC_FORCE 5
`define UFL_LC_BREAK 6
`define UFL_LC_DIV_ACC 7
`define UFL_FT_TABLE_LO 6
`define UFL_EF_ENH 4

// ============================================================
// Reset values
`define UFL_RST_LINE 8'h00
`define UFL_RST_BYTE 8'h00
`define UFL_RST_DIV_LOW 8'h01

`endif

/* File: rtl/ufl_pkg.sv */
// Types shared by the FIFO and line control block
package ufl_pkg;
    typedef enum logic [2:0] {
        UFL_PAR_NONE = 3'h0,
        UFL_PAR_ODD = 3'h1,
        UFL_PAR_EVEN = 3'h2,
        UFL_PAR_MARK = 3'h3,
        UFL_PAR_SPACE = 3'h4
    } ufl_parity_t;

    typedef enum logic [1:0] {
        UFL_BUF_IDLE = 2'h1,
        UFL_BUF_BUSY = 2'h2
    } ufl_bstate_t;

    typedef struct packed {
        logic fifo_en;
        logic dma_mode;
        logic [1:0] rx_sel;
        logic [1:0] tx_sel;
        logic [1:0] table_sel;
        logic [7:0] line_ctrl;
        logic [7:0] feature;
        logic [7:0] enh_feat;
        logic [7:0] div_low;
        logic [7:0] div_high;
        logic [7:0] div_frac;
        logic [7:0] rx_thr;
        logic [7:0] tx_thr;
    } ufl_regs_t;
endpackage

/* File: rtl/ufl_buf2.sv */
// Two-entry valid/ready buffer for data bytes
`timescale 1ns/10ps
module ufl_buf2 #(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] cnt;
    } ufl_buf_st_t;

    ufl_buf_st_t st_ff;
    ufl_buf_st_t nxt_st;
    logic push;
    logic pop;

    assign in_ready = (st_ff.cnt != 2'h2);
    assign out_valid = (st_ff.cnt != 2'h0);
    assign out_data = st_ff.mem[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (pop) begin
            nxt_st.mem[0] = st_ff.mem[1];
        end
        if (push) begin
            if (st_ff.cnt == 2'h0 || (st_ff.cnt == 2'h1 && pop)) begin
                nxt_st.mem[0] = in_data;
            end else begin
                nxt_st.mem[1] = in_data;
            end
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            nxt_st.cnt = 2'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

/* File: rtl/ufl_ctrl.sv */
// FIFO and line control logic with AXI4-Lite register slave
`timescale 1ns/10ps
`include "ufl_params.svh"
module ufl_ctrl #(
    parameter int DEPTH = 256,
    parameter int AW = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic tx_byte_valid,
    input wire logic tx_byte_ready,
    output logic [7:0] tx_byte,
    input wire logic rx_byte_valid,
    output logic rx_byte_ready,
    input wire logic [7:0] rx_byte,
    input wire logic tx_shift_bit,
    output logic tx_serial,
    output ufl_pkg::ufl_parity_t parity_mode,
    output logic rx_trigger_event,
    output logic tx_trigger_event
);
    localparam int CW = $clog2(DEPTH + 1);

    // ============================================================
    // State
    typedef struct packed {
        ufl_pkg::ufl_regs_t r;
        logic [CW-1:0] tx_cnt;
        logic [CW-1:0] rx_cnt;
        logic [CW-1:0] tx_cnt_d;
        logic [CW-1:0] rx_cnt_d;
        logic rx_evt;
        logic tx_evt;
        logic tx_flush;
        logic rx_flush;
        logic tx_serial;
        ufl_pkg::ufl_bstate_t wst;
        logic aw_got;
        logic w_got;
        logic [AW-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] tx_hold;
        logic tx_hold_v;
    } ufl_st_t;

    ufl_st_t st_ff;
    ufl_st_t nxt_st;
    logic [CW-1:0] rx_trig;
    logic [CW-1:0] tx_trig;
    logic txb_in_ready;
    logic rxb_out_valid;
    logic [7:0] rxb_out_data;
    logic rx_pop;
    logic tx_push;
    logic wr_fire;
    logic [7:0] wb;

    // ============================================================
    // Trigger tables
    always_comb begin
        // One table field feeds both directions
        case (st_ff.r.table_sel)
            2'h0: begin
                case (st_ff.r.rx_sel)
                    2'h0: rx_trig = CW'(1);
                    2'h1: rx_trig = CW'(4);
                    2'h2: rx_trig = CW'(8);
                    default: rx_trig = CW'(14);
                endcase
                tx_trig = CW'(1);
            end
            2'h1: begin
                case (st_ff.r.rx_sel)
                    2'h0: rx_trig = CW'(8);
                    2'h1: rx_trig = CW'(16);
                    2'h2: rx_trig = CW'(24);
                    default: rx_trig = CW'(28);
                endcase
                case (st_ff.r.tx_sel)
                    2'h0: tx_trig = CW'(16);
                    2'h1: tx_trig = CW'(8);
                    2'h2: tx_trig = CW'(24);
                    default: tx_trig = CW'(30);
                endcase
            end
            2'h2: begin
                case (st_ff.r.rx_sel)
                    2'h0: rx_trig = CW'(8);
                    2'h1: rx_trig = CW'(16);
                    2'h2: rx_trig = CW'(56);
                    default: rx_trig = CW'(60);
                endcase
                case (st_ff.r.tx_sel)
                    2'h0: tx_trig = CW'(8);
                    2'h1: tx_trig = CW'(16);
                    2'h2: tx_trig = CW'(32);
                    default: tx_trig = CW'(56);
                endcase
            end
            default: begin
                rx_trig = CW'(st_ff.r.rx_thr);
                tx_trig = CW'(st_ff.r.tx_thr);
            end
        endcase
    end

    // ============================================================
    // Parity decode
    always_comb begin
        if (!st_ff.r.line_ctrl[`UFL_LC_PAR_EN]) begin
            parity_mode = ufl_pkg::UFL_PAR_NONE;
        end else if (st_ff.r.line_ctrl[`UFL_LC_FORCE]) begin
            parity_mode = st_ff.r.line_ctrl[`UFL_LC_EVEN] ?
                ufl_pkg::UFL_PAR_SPACE : ufl_pkg::UFL_PAR_MARK;
        end else begin
            parity_mode = st_ff.r.line_ctrl[`UFL_LC_EVEN] ?
                ufl_pkg::UFL_PAR_EVEN : ufl_pkg::UFL_PAR_ODD;
        end
    end

    // ============================================================
    // Data buffers
    // Only the counts are flushed; shifters sit outside
    ufl_buf2 #(.W(8)) u_tx_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(st_ff.tx_flush),
        .in_valid(st_ff.tx_hold_v),
        .in_ready(txb_in_ready),
        .in_data(st_ff.tx_hold),
        .out_valid(tx_byte_valid),
        .out_ready(tx_byte_ready),
        .out_data(tx_byte)
    );

    ufl_buf2 #(.W(8)) u_rx_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(st_ff.rx_flush),
        .in_valid(rx_byte_valid),
        .in_ready(rx_byte_ready),
        .in_data(rx_byte),
        .out_valid(rxb_out_valid),
        .out_ready(rx_pop),
        .out_data(rxb_out_data)
    );

    // ============================================================
    // Bus handshakes
    assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign tx_serial = st_ff.tx_serial;
    assign rx_trigger_event = st_ff.rx_evt;
    assign tx_trigger_event = st_ff.tx_evt;
    assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.tx_hold_v;
    assign wb = st_ff.wdata[7:0];
    // Data register read pops one received byte while divisor access is clear
    assign rx_pop = s_axi_arvalid && s_axi_arready
        && s_axi_araddr == `UFL_OFS_DATA
        && !st_ff.r.line_ctrl[`UFL_LC_DIV_ACC];
    assign tx_push = st_ff.tx_hold_v && txb_in_ready;

    // ============================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tx_flush = 1'b0;
        nxt_st.rx_flush = 1'b0;
        nxt_st.rx_evt = 1'b0;
        nxt_st.tx_evt = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (tx_push) begin
            nxt_st.tx_hold_v = 1'b0;
        end
        // Writes stall while a data byte waits for buffer room
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = 2'h0;
            if (st_ff.wstrb[0]) begin
                case (st_ff.waddr)
                    `UFL_OFS_DATA: begin
                        if (st_ff.r.line_ctrl[`UFL_LC_DIV_ACC]) begin
                            nxt_st.r.div_low = wb;
                        end else begin
                            nxt_st.tx_hold = wb;
                            nxt_st.tx_hold_v = 1'b1;
                        end
                    end
                    `UFL_OFS_DIV_HIGH: begin
                        if (st_ff.r.line_ctrl[`UFL_LC_DIV_ACC]) begin
                            nxt_st.r.div_high = wb;
                        end
                    end
                    `UFL_OFS_DIV_FRAC: begin
                        if (st_ff.r.line_ctrl[`UFL_LC_DIV_ACC]) begin
                            nxt_st.r.div_frac = wb;
                        end
                    end
                    `UFL_OFS_FIFO_CTRL: begin
                        nxt_st.r.fifo_en = wb[`UFL_FC_ENABLE];
                        if (wb[`UFL_FC_ENABLE]) begin
                            nxt_st.r.dma_mode = wb[`UFL_FC_DMA];
                            nxt_st.r.rx_sel =
                                wb[`UFL_FC_RXSEL_LO +: 2];
                            nxt_st.tx_flush = wb[`UFL_FC_TX_RST];
                            nxt_st.rx_flush = wb[`UFL_FC_RX_RST];
                            if (st_ff.r.enh_feat[`UFL_EF_ENH]) begin
                                nxt_st.r.tx_sel =
                                    wb[`UFL_FC_TXSEL_LO +: 2];
                            end
                        end else begin
                            // Disabling empties both FIFOs
                            nxt_st.tx_flush = 1'b1;
                            nxt_st.rx_flush = 1'b1;
                        end
                    end
                    `UFL_OFS_LINE_CTRL: nxt_st.r.line_ctrl = wb;
                    `UFL_OFS_FEATURE: begin
                        nxt_st.r.feature = wb;
                        nxt_st.r.table_sel =
                            wb[`UFL_FT_TABLE_LO +: 2];
                    end
                    `UFL_OFS_ENH_FEAT: nxt_st.r.enh_feat = wb;
                    `UFL_OFS_RX_THR: nxt_st.r.rx_thr = wb;
                    `UFL_OFS_TX_THR: nxt_st.r.tx_thr = wb;
                    `UFL_OFS_STATUS: nxt_st.bresp = 2'h0;
                    default: nxt_st.bresp = 2'h2;
                endcase
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = 2'h0;
            nxt_st.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                `UFL_OFS_DATA: begin
                    nxt_st.rdata[7:0] =
                        st_ff.r.line_ctrl[`UFL_LC_DIV_ACC] ?
                        st_ff.r.div_low : rxb_out_data;
                end
                `UFL_OFS_DIV_HIGH: nxt_st.rdata[7:0] = st_ff.r.div_high;
                `UFL_OFS_DIV_FRAC: nxt_st.rdata[7:0] = st_ff.r.div_frac;
                // Write-only register reads as zero
                `UFL_OFS_FIFO_CTRL: nxt_st.rdata = 32'h0000_0000;
                `UFL_OFS_LINE_CTRL: nxt_st.rdata[7:0] = st_ff.r.line_ctrl;
                `UFL_OFS_FEATURE: nxt_st.rdata[7:0] = st_ff.r.feature;
                `UFL_OFS_ENH_FEAT: nxt_st.rdata[7:0] = st_ff.r.enh_feat;
                `UFL_OFS_RX_THR: nxt_st.rdata[7:0] = st_ff.r.rx_thr;
                `UFL_OFS_TX_THR: nxt_st.rdata[7:0] = st_ff.r.tx_thr;
                `UFL_OFS_STATUS: begin
                    nxt_st.rdata[CW-1:0] = st_ff.rx_cnt;
                    nxt_st.rdata[8 +: CW] = st_ff.tx_cnt;
                    nxt_st.rdata[24] = st_ff.r.fifo_en;
                    nxt_st.rdata[25] = st_ff.r.dma_mode;
                end
                default: nxt_st.rresp = 2'h2;
            endcase
        end
        // Level counters track the FIFO traffic
        nxt_st.tx_cnt = st_ff.tx_cnt + CW'(tx_push)
            - CW'(tx_byte_valid && tx_byte_ready);
        nxt_st.rx_cnt = st_ff.rx_cnt
            + CW'(rx_byte_valid && rx_byte_ready)
            - CW'(rxb_out_valid && rx_pop);
        if (st_ff.tx_flush) begin
            nxt_st.tx_cnt = '0;
        end
        if (st_ff.rx_flush) begin
            nxt_st.rx_cnt = '0;
        end
        nxt_st.tx_cnt_d = st_ff.tx_cnt;
        nxt_st.rx_cnt_d = st_ff.rx_cnt;
        // Compare against the live trigger every cycle while fifo_en is set
        if (st_ff.r.fifo_en) begin
            nxt_st.rx_evt = st_ff.rx_cnt >= rx_trig
                && st_ff.rx_cnt_d < rx_trig;
            nxt_st.tx_evt = (st_ff.tx_cnt < tx_trig
                && st_ff.tx_cnt_d >= tx_trig)
                || (st_ff.tx_cnt == '0 && st_ff.tx_cnt_d != '0);
        end
        // Break overrides the shifter bit
        nxt_st.tx_serial = st_ff.r.line_ctrl[`UFL_LC_BREAK] ?
            1'b0 : tx_shift_bit;
    end

    // ============================================================
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.r.line_ctrl <= `UFL_RST_LINE;
            st_ff.r.div_low <= `UFL_RST_DIV_LOW;
            st_ff.wst <= ufl_pkg::UFL_BUF_IDLE;
            st_ff.tx_serial <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

/* File: verification/ufl_ctrl_sva.sv */
// Port assertions for the FIFO and line control block
`timescale 1ns/10ps
module ufl_ctrl_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_shift_bit,
    input wire logic tx_serial,
    input wire ufl_pkg::ufl_parity_t parity_mode
);
    // ====================
    // Line control shadow
    // Aged so that no write latency is assumed
    logic [7:0] lcr_ff;
    logic [2:0] age_ff;
    logic [2:0] pe;
    logic lw;
    assign lw = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr == 6'h0C && s_axi_wstrb[0];
    assign pe = !lcr_ff[3] ? 3'h0 : !lcr_ff[5]
        ? {1'b0, lcr_ff[4], !lcr_ff[4]} : (lcr_ff[4] ? 3'h4 : 3'h3);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lcr_ff <= 8'h00;
            age_ff <= 3'h0;
        end else if (lw) begin
            lcr_ff <= s_axi_wdata[7:0];
            age_ff <= 3'h0;
        end else if (age_ff != 3'h7) begin
            age_ff <= age_ff + 3'h1;
        end
    end
    // ====================
    // Assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    break_low_a: assert property (
        age_ff > 3'h4 && lcr_ff[6] |-> !tx_serial)
        else $error("Serial line high during break");
    line_follow_a: assert property (
        age_ff > 3'h5 && !lcr_ff[6] |-> tx_serial == $past(tx_shift_bit))
        else $error("Serial line does not follow shifter");
    parity_map_a: assert property (
        age_ff > 3'h4 |-> parity_mode == pe)
        else $error("Parity mode wrong");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data not held");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late");
    fifo_ctrl_wo_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 6'h08
        |=> s_axi_rdata == 32'h0) else $error("FIFO control readable");
    unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr >= 6'h28 |=> s_axi_rresp == 2'h2)
        else $error("Unmapped read not refused");
endmodule

/* File: verification/ufl_far_end.sv */
// Far-side model: transmit and receive shifters of the channel
`timescale 1ns/10ps
module ufl_far_end (
    input wire logic aclk,
    input wire logic stall,
    input wire logic tx_byte_valid,
    output logic tx_byte_ready,
    input wire logic [7:0] tx_byte,
    output logic rx_byte_valid,
    input wire logic rx_byte_ready,
    output logic [7:0] rx_byte,
    output logic tx_shift_bit
);
    logic [7:0] got_q[$];
    int n_late;
    initial begin
        tx_byte_ready = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h5A;
        tx_shift_bit = 1'b1;
    end
    // Toggling level exposes a stuck or stale serial output
    always @(posedge aclk) begin
        tx_shift_bit <= ~tx_shift_bit;
        tx_byte_ready <= !stall;
        if (tx_byte_valid === 1'b1 && tx_byte_ready)
            got_q.push_back(tx_byte);
    end
    // Idle data line shows the inverse of the last byte
    task automatic push(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge aclk);
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        do begin
            @(negedge aclk);
            n++;
        end while (rx_byte_ready !== 1'b1 && n < 200);
        if (n >= 200) n_late++;
        @(posedge aclk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
endmodule

/* File: verification/test_uart_fifo_and_line_control.sv */
// Self-checking bench for the FIFO and line control block
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED at %0t: got %0h exp %0h", \
    $time, g, e); end end
module test_uart_fifo_and_line_control;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, stall;
    logic tx_byte_valid, tx_byte_ready, rx_byte_valid, rx_byte_ready;
    logic tx_shift_bit, tx_serial, rx_trigger_event, tx_trigger_event;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] tx_byte, rx_byte;
    ufl_pkg::ufl_parity_t parity_mode;
    int n_mismatch, check_count, rx_ev, tx_ev, e;
    ufl_ctrl u_ufl_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_byte_valid,
        .tx_byte_ready, .tx_byte, .rx_byte_valid, .rx_byte_ready,
        .rx_byte, .tx_shift_bit, .tx_serial, .parity_mode,
        .rx_trigger_event, .tx_trigger_event);
    ufl_far_end u_ufl_far_end (.aclk, .stall, .tx_byte_valid,
        .tx_byte_ready, .tx_byte, .rx_byte_valid, .rx_byte_ready,
        .rx_byte, .tx_shift_bit);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rx_trigger_event === 1'b1) rx_ev++;
        if (tx_trigger_event === 1'b1) tx_ev++;
    end
    function automatic logic [2:0] pexp(input logic [2:0] f);
        if (!f[0]) return 3'h0;
        return f[2] ? (f[1] ? 3'h4 : 3'h3) : (f[1] ? 3'h2 : 3'h1);
    endfunction
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo(inout int n);
        n++;
        if (n > 300) begin
            n_mismatch++;
            $display("Wait timed out at %0t", $time);
            give_verdict();
        end
    endtask
    // ====================
    // Bus cycles
    // Ready raised late on purpose to exercise held answers
    task automatic answer(input bit r);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            tmo(n);
        end while ((r ? s_axi_rvalid : s_axi_bvalid) !== 1'b1);
        @(posedge aclk);
        if (r) s_axi_rready <= 1'b1;
        else s_axi_bready <= 1'b1;
        @(negedge aclk);
        rd = s_axi_rdata;
        rs = r ? s_axi_rresp : s_axi_bresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        s_axi_bready <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        int n;
        logic ak, wk;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // Valid updates are not visible yet, so test after the first edge
        do begin
            @(negedge aclk);
            ak = s_axi_awready || !s_axi_awvalid;
            wk = s_axi_wready || !s_axi_wvalid;
            @(posedge aclk);
            if (ak) s_axi_awvalid <= 1'b0;
            if (wk) s_axi_wvalid <= 1'b0;
            tmo(n);
        end while (!(ak && wk));
        answer(1'b0);
    endtask
    task automatic rdr(input logic [5:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            tmo(n);
        end while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        answer(1'b1);
    endtask
    // ====================
    // Scenarios
    task automatic t_regs();
        rdr(6'h0C);
        `CHK(rd[7:0], 8'h00)
        rdr(6'h24);
        `CHK(rd[25:24], 2'h0)
        wr(6'h08, 8'h09);
        rdr(6'h24);
        `CHK(rd[25:24], 2'h3)
        wr(6'h08, 8'h00);
        rdr(6'h24);
        `CHK(rd[25:24], 2'h2)
        rdr(6'h08);
        `CHK(rd, 32'h0)
        wr(6'h28, 8'h00);
        `CHK(rs, 2'h2)
        rdr(6'h28);
        `CHK(rs, 2'h2)
        $display("t_regs done");
    endtask
    task automatic t_par();
        logic [2:0] f;
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            wr(6'h0C, {2'b00, f, 3'b000});
            repeat (6) @(posedge aclk);
            `CHK(parity_mode, pexp(f))
            rdr(6'h0C);
            `CHK(rd[7:0], {2'b00, f, 3'b000})
        end
        $display("t_par done");
    endtask
    task automatic t_brk();
        wr(6'h0C, 8'h40);
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            @(negedge aclk);
            `CHK(tx_serial, 1'b0)
        end
        @(posedge aclk);
        wr(6'h0C, 8'h00);
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        `CHK(tx_serial, ~tx_shift_bit)
        @(posedge aclk);
        $display("t_brk done");
    endtask
    task automatic t_div();
        wr(6'h0C, 8'h80);
        rdr(6'h00);
        `CHK(rd[7:0], 8'h01)
        wr(6'h00, 8'h5A);
        rdr(6'h00);
        `CHK(rd[7:0], 8'h5A)
        wr(6'h0C, 8'h00);
        wr(6'h08, 8'h01);
        u_ufl_far_end.push(8'hC3);
        repeat (6) @(posedge aclk);
        rdr(6'h00);
        `CHK(rd[7:0], 8'hC3)
        $display("t_div done");
    endtask
    task automatic t_rx();
        wr(6'h14, 8'hC0);
        // Buffer holds two bytes, so the threshold must stay reachable
        wr(6'h1C, 8'h02);
        e = rx_ev;
        u_ufl_far_end.push(8'h01);
        repeat (8) @(posedge aclk);
        `CHK(rx_ev, e)
        u_ufl_far_end.push(8'h02);
        repeat (8) @(posedge aclk);
        `CHK(rx_ev, e + 1)
        rdr(6'h24);
        `CHK(rd[8:0], 9'h002)
        wr(6'h08, 8'h03);
        rdr(6'h24);
        `CHK(rd[8:0], 9'h000)
        $display("t_rx done");
    endtask
    task automatic t_tx();
        stall <= 1'b1;
        @(posedge aclk);
        wr(6'h00, 8'h11);
        wr(6'h00, 8'h22);
        repeat (4) @(posedge aclk);
        `CHK(u_ufl_far_end.got_q.size(), 0)
        e = tx_ev;
        stall <= 1'b0;
        repeat (10) @(posedge aclk);
        `CHK(tx_ev, e + 1)
        `CHK(u_ufl_far_end.got_q.size(), 2)
        `CHK(u_ufl_far_end.got_q[0], 8'h11)
        `CHK(u_ufl_far_end.got_q[1], 8'h22)
        stall <= 1'b1;
        wr(6'h00, 8'h33);
        wr(6'h08, 8'h05);
        rdr(6'h24);
        `CHK(rd[16:8], 9'h000)
        stall <= 1'b0;
        $display("t_tx done");
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 6'h00;
        s_axi_araddr = 6'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        stall = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_par();
        t_brk();
        t_div();
        t_rx();
        t_tx();
        `CHK(u_ufl_far_end.n_late, 0)
        give_verdict();
    end
endmodule
bind ufl_ctrl ufl_ctrl_chk u_ufl_ctrl_chk (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_shift_bit,
    .tx_serial, .parity_mode);
